// [prr_pkg.sv]
// Purpose: shared constants and types of the psram refresh and chip-select block
// Assumes: 25 MHz processor clock, 20-bit physical address
// Notes:   the shared numbers used by the logic live here; RELOAD_W and MID_BLK_W are module parameters
package prr_pkg;
  localparam int CLK_PERIOD_NS   = 40;
  localparam int PSRAM_ACCESS_NS = 70;
  // least access time, rounded up to whole clocks
  localparam int PSRAM_ACCESS_CYC = (PSRAM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] PSRAM_WAIT_MIN = 2'(PSRAM_ACCESS_CYC - 1);
  localparam int REFRESH_MIN_RELOAD = 18;
  localparam int RELOAD_W_MIN       = 5;
  localparam int RELOAD_W_MAX       = 16;
  localparam int ADDR_W             = 20;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 20'h00000;
  localparam logic [1:0] WAIT_ONE   = 2'h1;
  localparam logic [1:0] WAIT_NONE  = 2'h0;
  // hit vector layout
  localparam int HIT_LOW = 0;
  localparam int HIT_MID = 1;
  localparam int MID_NUM = 4;
  localparam int HIT_UP  = 5;
  localparam int HIT_W   = 6;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_T1   = 4'h1,
    ST_T2   = 4'h2,
    ST_T3   = 4'h3,
    ST_TW   = 4'h4,
    ST_T4   = 4'h5,
    ST_PRE  = 4'h6,
    ST_RF1  = 4'h7,
    ST_RF2  = 4'h8,
    ST_RF3  = 4'h9,
    ST_RF4  = 4'hA
  } prr_state_t;
endpackage

// [prr_rf_if.sv]
// Purpose: link between the bus sequencer and the refresh interval timer
// Assumes: one clock domain
// Notes:   tick is a one-cycle pulse
interface prr_rf_if #(parameter int W = 9);
  logic         en;
  logic [W-1:0] reload;
  logic         tick;
  modport timer (input en, input reload, output tick);
  modport ctl   (output en, output reload, input tick);
endinterface

// [prr_refresh_timer.sv]
// Purpose: refresh interval down-counter
// Assumes: reload held stable while enabled
// Notes:   a reload below two still ticks every clock
module prr_refresh_timer #(
  parameter int RELOAD_W = 9
) (
  // clock and reset
  input logic     mclk,
  input logic     arst_n,
  // sequencer link
  prr_rf_if.timer rf
);
  localparam logic [RELOAD_W-1:0] CNT_ONE = RELOAD_W'(1);

  logic [RELOAD_W-1:0] cnt_r;
  logic                tick_r;

  assign rf.tick = tick_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (!rf.en) begin
      cnt_r  <= rf.reload;
      tick_r <= 1'b0;
    end else if (cnt_r <= CNT_ONE) begin
      cnt_r  <= rf.reload;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r - CNT_ONE;
      tick_r <= 1'b0;
    end
  end

  a_tick_spacing: assert property (@(posedge mclk) disable iff (!arst_n)
    rf.tick && rf.en && (rf.reload >= RELOAD_W'(prr_pkg::REFRESH_MIN_RELOAD))
      |=> !rf.tick [*8])
    else $error("refresh ticks closer than the reload interval");
endmodule

// [prr_ctrl.sv]
// Purpose: psram chip-select timing and auto-refresh sequencer
// Assumes: core raises req only while req_ready is high; config ports are stable when idle
// Notes:   mode bit is sampled only between cycles so a cycle never changes shape midway

module prr_ctrl #(
  parameter int RELOAD_W = 9,
  parameter int MID_BLK_W = 13
) (
  // clock and reset
  input  logic                      mclk,
  input  logic                      arst_n,
  // core bus request
  input  logic                      req,
  input  logic [prr_pkg::ADDR_W-1:0] req_addr,
  output logic                      req_ready,
  output logic                      cyc_done,
  // configuration
  input  logic                      psram_mode_on,
  input  logic                      ignore_ext_ready,
  input  logic [1:0]                wait_state_count,
  input  logic [prr_pkg::ADDR_W-1:0] low_end_addr,
  input  logic [prr_pkg::ADDR_W-1:0] mid_base_addr,
  input  logic [prr_pkg::ADDR_W-1:0] upper_start_addr,
  input  logic [RELOAD_W-1:0]       refresh_reload,
  input  logic [prr_pkg::ADDR_W-1:0] refresh_addr_cnt,
  // pins
  input  logic                      ext_ready,
  output logic                      low_region_chip_sel_n,
  output logic [2:0]                mid_region_chip_sels_n,
  output logic                      mid3_refresh_pin_n,
  output logic                      upper_region_chip_sel_n,
  output logic [prr_pkg::ADDR_W-1:0] a_bus,
  output logic                      a_bus_oe,
  // status
  output logic                      refresh_active
);
  if (RELOAD_W < prr_pkg::RELOAD_W_MIN || RELOAD_W > prr_pkg::RELOAD_W_MAX) begin : g_chk
    $error("RELOAD_W out of range");
  end
  if (MID_BLK_W < 1 || MID_BLK_W > prr_pkg::ADDR_W - 3) begin : g_chk_mid
    $error("MID_BLK_W out of range");
  end

  function automatic logic [prr_pkg::HIT_W-1:0] region_hit(
    input logic [prr_pkg::ADDR_W-1:0] a,
    input logic [prr_pkg::ADDR_W-1:0] low_end,
    input logic [prr_pkg::ADDR_W-1:0] mid_base,
    input logic [prr_pkg::ADDR_W-1:0] up_start);
    logic [prr_pkg::HIT_W-1:0] h;
    h = '0;
    if (a >= up_start) begin
      h[prr_pkg::HIT_UP] = 1'b1;
    end else if (a[prr_pkg::ADDR_W-1:MID_BLK_W+2] == mid_base[prr_pkg::ADDR_W-1:MID_BLK_W+2]) begin
      h[prr_pkg::HIT_MID + int'(a[MID_BLK_W+1:MID_BLK_W])] = 1'b1;
    end else if (a <= low_end) begin
      h[prr_pkg::HIT_LOW] = 1'b1;
    end
    return h;
  endfunction

  prr_rf_if #(.W(RELOAD_W)) rf ();

  prr_refresh_timer #(.RELOAD_W(RELOAD_W)) u_timer (
    .mclk   (mclk),
    .arst_n (arst_n),
    .rf     (rf.timer)
  );

  prr_pkg::prr_state_t       st_r, st_nxt;
  logic                      mode_r, mode_nxt;
  logic                      pend_r, pend_nxt;
  logic [1:0]                wcnt_r;
  logic [prr_pkg::HIT_W-1:0] hit_r, hit_nxt, rhit;
  logic [prr_pkg::ADDR_W-1:0] addr_r, addr_nxt;
  logic                      rdy_meta_r, rdy_s_r;
  logic                      take, start_rf, rdy_ok;
  logic [1:0]                eff_wait;
  logic                      cs_act, ps_act, rf_act, strobe, oe_nxt;
  logic [prr_pkg::MID_NUM-1:0] mid_nxt;
  logic                      first_r;

  assign rf.en     = mode_r;
  assign rf.reload = refresh_reload;

  // ready is a pin: two flops before use
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdy_meta_r <= 1'b0;
      rdy_s_r    <= 1'b0;
    end else begin
      rdy_meta_r <= ext_ready;
      rdy_s_r    <= rdy_meta_r;
    end
  end

  assign rdy_ok   = ignore_ext_ready || rdy_s_r;
  assign take     = (st_r == prr_pkg::ST_IDLE) && req && req_ready;
  assign start_rf = (st_r == prr_pkg::ST_IDLE) && !take && mode_r && (pend_r || rf.tick);
  // psram parts never get fewer than the minimum waits
  assign eff_wait = (mode_r && wait_state_count < prr_pkg::PSRAM_WAIT_MIN) ?
                    prr_pkg::PSRAM_WAIT_MIN : wait_state_count;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      prr_pkg::ST_IDLE: begin
        if (take) begin
          st_nxt = prr_pkg::ST_T1;
        end else if (start_rf) begin
          st_nxt = prr_pkg::ST_RF1;
        end
      end
      prr_pkg::ST_T1: st_nxt = prr_pkg::ST_T2;
      prr_pkg::ST_T2: st_nxt = prr_pkg::ST_T3;
      prr_pkg::ST_T3: begin
        st_nxt = (wcnt_r != prr_pkg::WAIT_NONE || !rdy_ok) ? prr_pkg::ST_TW : prr_pkg::ST_T4;
      end
      prr_pkg::ST_TW: begin
        if (wcnt_r <= prr_pkg::WAIT_ONE && rdy_ok) begin
          st_nxt = prr_pkg::ST_T4;
        end
      end
      prr_pkg::ST_T4: begin
        // precharge slot only after a low region psram access
        st_nxt = (mode_r && hit_r[prr_pkg::HIT_LOW]) ? prr_pkg::ST_PRE : prr_pkg::ST_IDLE;
      end
      prr_pkg::ST_PRE: st_nxt = prr_pkg::ST_IDLE;
      prr_pkg::ST_RF1: st_nxt = prr_pkg::ST_RF2;
      prr_pkg::ST_RF2: st_nxt = prr_pkg::ST_RF3;
      prr_pkg::ST_RF3: st_nxt = prr_pkg::ST_RF4;
      default:         st_nxt = prr_pkg::ST_IDLE;
    endcase
  end

  always_comb begin
    mode_nxt = (st_r == prr_pkg::ST_IDLE) ? psram_mode_on : mode_r;
    // a tick in the clearing cycle survives unless it is the one being served
    pend_nxt = mode_r && ((rf.tick && !(start_rf && !pend_r)) || (pend_r && !start_rf));
    hit_nxt  = take ? region_hit(req_addr, low_end_addr, mid_base_addr, upper_start_addr) : hit_r;
    addr_nxt = take ? req_addr : addr_r;
    rhit     = region_hit(refresh_addr_cnt, low_end_addr, mid_base_addr, upper_start_addr);
    cs_act   = st_nxt inside {prr_pkg::ST_T1, prr_pkg::ST_T2, prr_pkg::ST_T3, prr_pkg::ST_TW};
    ps_act   = st_nxt inside {prr_pkg::ST_T2, prr_pkg::ST_T3, prr_pkg::ST_TW};
    rf_act   = st_nxt inside {prr_pkg::ST_RF1, prr_pkg::ST_RF2, prr_pkg::ST_RF3};
    strobe   = st_nxt inside {prr_pkg::ST_RF2, prr_pkg::ST_RF3};
    oe_nxt   = cs_act || (st_nxt == prr_pkg::ST_T4);
    for (int i = 0; i < prr_pkg::MID_NUM; i++) begin
      mid_nxt[i] = !((cs_act && hit_nxt[prr_pkg::HIT_MID+i]) ||
                     (rf_act && rhit[prr_pkg::HIT_MID+i]));
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r   <= prr_pkg::ST_IDLE;
      mode_r <= 1'b0;
      pend_r <= 1'b0;
      hit_r  <= '0;
      addr_r <= prr_pkg::ADDR_ZERO;
      wcnt_r <= prr_pkg::WAIT_NONE;
    end else begin
      st_r   <= st_nxt;
      mode_r <= mode_nxt;
      pend_r <= pend_nxt;
      hit_r  <= hit_nxt;
      addr_r <= addr_nxt;
      if (st_r == prr_pkg::ST_T1) begin
        wcnt_r <= eff_wait;
      end else if (st_r == prr_pkg::ST_TW && wcnt_r != prr_pkg::WAIT_NONE) begin
        wcnt_r <= wcnt_r - prr_pkg::WAIT_ONE;
      end
    end
  end

  // pin and status flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      low_region_chip_sel_n   <= 1'b1;
      mid_region_chip_sels_n  <= '1;
      mid3_refresh_pin_n      <= 1'b1;
      upper_region_chip_sel_n <= 1'b1;
      a_bus                   <= prr_pkg::ADDR_ZERO;
      a_bus_oe                <= 1'b0;
      req_ready               <= 1'b0;
      cyc_done                <= 1'b0;
      refresh_active          <= 1'b0;
    end else begin
      // low select only from access decode, never from refresh
      low_region_chip_sel_n   <= !(hit_nxt[prr_pkg::HIT_LOW] &&
                                   (mode_nxt ? ps_act : cs_act));
      mid_region_chip_sels_n  <= mid_nxt[2:0];
      mid3_refresh_pin_n      <= mode_nxt ? !strobe : mid_nxt[3];
      // upper decode also sees the refresh address
      upper_region_chip_sel_n <= !((cs_act && hit_nxt[prr_pkg::HIT_UP]) ||
                                   (rf_act && rhit[prr_pkg::HIT_UP]));
      a_bus                   <= oe_nxt ? addr_nxt : prr_pkg::ADDR_ZERO;
      a_bus_oe                <= oe_nxt;
      req_ready               <= (st_nxt == prr_pkg::ST_IDLE) && !pend_nxt;
      cyc_done                <= (st_nxt == prr_pkg::ST_T4);
      refresh_active          <= rf_act || (st_nxt == prr_pkg::ST_RF4);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  a_low_sel_region: assert property (@(posedge mclk) disable iff (!arst_n)
    !low_region_chip_sel_n |-> hit_r[prr_pkg::HIT_LOW] && !refresh_active)
    else $error("low select outside a low region access");
  a_precharge_gap: assert property (@(posedge mclk) disable iff (!arst_n)
    mode_r && $rose(low_region_chip_sel_n) |-> low_region_chip_sel_n [*2])
    else $error("psram precharge gap too short");
  a_one_wait: assert property (@(posedge mclk) disable iff (!arst_n)
    mode_r && $fell(low_region_chip_sel_n) |-> !low_region_chip_sel_n [*3])
    else $error("psram access shorter than one wait state");
  a_reset_off: assert property (@(posedge mclk) disable iff (!arst_n)
    first_r |-> !mode_r && mid3_refresh_pin_n)
    else $error("psram mode on right after reset");
  a_mode_idle: assert property (@(posedge mclk) disable iff (!arst_n)
    $changed(mode_r) |-> $past(st_r) == prr_pkg::ST_IDLE)
    else $error("psram mode changed inside a cycle");
  a_no_row_addr: assert property (@(posedge mclk) disable iff (!arst_n)
    refresh_active |-> !a_bus_oe && a_bus == prr_pkg::ADDR_ZERO)
    else $error("address driven during refresh");
  a_refresh_issue: assert property (@(posedge mclk) disable iff (!arst_n)
    rf.tick && mode_r && st_r == prr_pkg::ST_IDLE && !take |->
      ##2 !mid3_refresh_pin_n [*2] ##1 mid3_refresh_pin_n)
    else $error("refresh strobe not issued after tick");
  a_pin_no_cs: assert property (@(posedge mclk) disable iff (!arst_n)
    mode_r && !(st_r inside {prr_pkg::ST_RF2, prr_pkg::ST_RF3}) |-> mid3_refresh_pin_n)
    else $error("shared pin acted as a select in psram mode");
  a_refresh_idle: assert property (@(posedge mclk) disable iff (!arst_n)
    !mid3_refresh_pin_n && mode_r |-> low_region_chip_sel_n && refresh_active)
    else $error("low select active during refresh");
endmodule

// [prr_psram_model.sv]
// Purpose: behavioural psram beside the low select, with auto refresh
// Assumes: select and strobe active low; one clock
// Notes:   slow mode holds ready low for the first three cycles of a selection
module prr_psram_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // pins
  input  wire logic       cs_n,
  input  wire logic       refresh_strobe_n,
  input  wire logic       slow,
  output logic            ext_ready,
  // observation
  output logic [7:0]      row_r
);
  logic [1:0] wait_r;
  logic       strobe_d_r;
  // rows sequence inside the part, so no row address is ever taken
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      row_r      <= 8'h00;
      strobe_d_r <= 1'b1;
    end else begin
      strobe_d_r <= refresh_strobe_n;
      if (!strobe_d_r && refresh_strobe_n) row_r <= row_r + 8'h01;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) wait_r <= 2'h0;
    else if (cs_n) wait_r <= 2'h0;
    else if (wait_r != 2'h3) wait_r <= wait_r + 2'h1;
  end
  assign ext_ready = !slow || (wait_r == 2'h3);
endmodule

// [testbench.sv]
// Purpose: self-checking bench of the psram select and refresh sequencer
// Assumes: 25 MHz clock; outputs sampled 1 ns after the edge
// Notes:   vector bit 0 is the first cycle after the take edge, or the first refresh_active cycle in t_refresh
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, arst_n = 0, req = 0, psram_mode_on = 0, ignore_ext_ready = 0, slow = 0;
  logic [1:0] wait_state_count = 2'h0;
  logic [19:0] req_addr = 20'h00000, a_bus;
  logic [8:0] refresh_reload = 9'h1FF;
  logic req_ready, cyc_done, ext_ready, low_cs_n, pin_n, up_n, a_bus_oe, refresh_active;
  logic [2:0] mid_n;
  logic [7:0] row, v_low, v_pin, v_done, v_oe, v_rdy, v_act, v_abz;
  int failures = 0, samples_checked = 0;
  always #20 mclk = ~mclk;
  prr_ctrl i_dut (.mclk(mclk), .arst_n(arst_n), .req(req), .req_addr(req_addr),
    .req_ready(req_ready), .cyc_done(cyc_done), .psram_mode_on(psram_mode_on),
    .ignore_ext_ready(ignore_ext_ready), .wait_state_count(wait_state_count),
    .low_end_addr(20'h3FFFF), .mid_base_addr(20'h80000), .upper_start_addr(20'hC0000),
    .refresh_reload(refresh_reload), .refresh_addr_cnt(20'h00000), .ext_ready(ext_ready),
    .low_region_chip_sel_n(low_cs_n), .mid_region_chip_sels_n(mid_n),
    .mid3_refresh_pin_n(pin_n), .upper_region_chip_sel_n(up_n), .a_bus(a_bus),
    .a_bus_oe(a_bus_oe), .refresh_active(refresh_active));
  prr_psram_model i_mem (.mclk(mclk), .arst_n(arst_n), .cs_n(low_cs_n),
    .refresh_strobe_n(pin_n), .slow(slow), .ext_ready(ext_ready), .row_r(row));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  task automatic cap(input int n);
    {v_low, v_pin, v_done, v_oe, v_rdy, v_act, v_abz} = 56'h00000000000000;
    for (int i = 0; i < n; i++) begin
      {v_low[i], v_pin[i], v_done[i], v_oe[i]} = {low_cs_n, pin_n, cyc_done, a_bus_oe};
      {v_rdy[i], v_act[i], v_abz[i]} = {req_ready, refresh_active, a_bus === 20'h00000};
      step();
    end
  endtask
  // software setup: reload, ready ignore and wait states before any psram access
  task automatic cfg(input logic on, input logic [1:0] w, input logic [8:0] rl);
    @(posedge mclk);
    psram_mode_on <= on;
    wait_state_count <= w;
    refresh_reload <= rl;
    ignore_ext_ready <= on;
    repeat (3) step();
  endtask
  task automatic issue(input logic [19:0] a);
    for (int k = 0; k < 50 && req_ready !== 1'b1; k++) step();
    @(posedge mclk);
    req <= 1'b1;
    req_addr <= a;
    // hold the request until an edge that sees the block ready
    do begin
      @(posedge mclk);
    end while (req_ready !== 1'b1);
    req <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    step();
    chk({low_cs_n, pin_n, up_n, mid_n, a_bus_oe, req_ready, refresh_active}, 20'h001F8);
    @(posedge mclk);
    arst_n <= 1'b1;
    step();
    chk(req_ready, 20'h1);
  endtask
  task automatic t_mid3_plain;
    issue(20'h86000);
    chk(a_bus, 20'h86000);
    cap(5);
    chk({v_pin, v_done}, 20'h01808);
    chk(v_oe, 20'h0000F);
    issue(20'hC4000);
    chk({up_n, mid_n}, 20'h00007);
    cap(5);
    chk(v_done, 20'h00008);
    issue(20'h80000);
    chk({up_n, mid_n}, 20'h0000E);
    cap(5);
    chk(v_done, 20'h00008);
  endtask
  task automatic t_slow_low;
    int n;
    slow <= 1'b1;
    issue(20'h01000);
    chk(low_cs_n, 20'h0);
    for (n = 1; n < 16 && cyc_done !== 1'b1; n++) step();
    chk(n > 4 && n < 16, 20'h1);
    slow <= 1'b0;
  endtask
  task automatic t_psram_low;
    for (int w = 0; w < 2; w++) begin
      cfg(1'b1, 2'(w), 9'h1FF);
      issue(20'h01000);
      cap(7);
      chk({v_low, v_done}, 20'h07110);
      chk(v_oe, 20'h0001F);
      chk(v_rdy, 20'h40);
    end
    issue(20'h86000);
    cap(5);
    chk(v_pin, 20'h1F);
  endtask
  task automatic t_refresh;
    int k;
    logic [7:0] row0;
    cfg(1'b0, 2'h1, 9'h1FF);
    cfg(1'b1, 2'h1, 9'h012);
    for (k = 0; k < 40 && refresh_active !== 1'b1; k++) step();
    row0 = row;
    cap(4);
    chk({v_pin, v_low}, 20'h0090F);
    chk({v_oe, v_act}, 20'h0000F);
    chk(v_abz, 20'h0000F);
    for (k = 4; k < 40 && refresh_active !== 1'b1; k++) step();
    chk(20'(k), 20'h00012);
    cap(4);
    chk(row - row0, 20'h2);
  endtask
  task automatic t_mode_off;
    logic bad;
    bad = 1'b0;
    cfg(1'b0, 2'h1, 9'h012);
    repeat (60) begin
      bad = bad | refresh_active | !pin_n;
      step();
    end
    chk(bad, 20'h0);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // generous limit, the whole sequence needs under two hundred cycles
  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    final_report();
  end
  initial begin
    t_reset();
    t_mid3_plain();
    t_slow_low();
    t_psram_low();
    t_refresh();
    t_mode_off();
    final_report();
  end
endmodule
